// >>> itd_pkg.sv
// Purpose: shared constants and types for interface topology detection
// Assumes: one 10 MHz clock, eight detectable wires per component
// Notes:   wire indices are shared by the drive, observe and force vectors
package itd_pkg;

   // wire slots: outputs and observed inputs use the same numbering
   localparam int NWIRE        = 8;
   localparam int W_TRC_VALID  = 0;
   localparam int W_TRC_READY  = 1;
   localparam int W_HALT_ACK   = 2;
   localparam int W_ALT_LINK   = 3;
   localparam int W_POINT      = 4;
   localparam int W_POINT_ACK  = 5;
   localparam int W_CHAN_OUT   = 6;
   localparam int W_CHAN_ACK   = 7;
   localparam int IDX_W        = 3;

   // extra synchronised control inputs behind the eight observed wires
   localparam int NSYNC        = 11;
   localparam int S_CHAN_ASYNC = 8;
   localparam int S_SCAN_FORCE = 9;
   localparam int S_SCAN_VALUE = 10;

   // hardware configuration of this component
   localparam logic POINT_ACK_PRESENT = 1'b1;
   localparam logic HALT_MM_FORCE     = 1'b0;
   localparam logic [NWIRE-1:0] FORCE_ALLOW = HALT_MM_FORCE ? 8'hFF : 8'hFB;

   // affinity words, values arbitrary
   localparam logic [31:0] AFF_LOW_VALUE  = 32'h0000_0001;
   localparam logic [31:0] AFF_HIGH_VALUE = 32'h0000_0000;

   // settle time after a drive change: output flop, far register and two sync stages
   localparam int CLK_PERIOD_NS = 100;
   localparam int SETTLE_NS     = 400;
   localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = 3;
   localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYCLES - 1);

   typedef enum logic [1:0] {
      ITD_IF_TRACE = 2'b00,
      ITD_IF_HALT  = 2'b01,
      ITD_IF_POINT = 2'b10,
      ITD_IF_CHAN  = 2'b11
   } itd_if_t;

   typedef enum logic [2:0] {
      ITD_PH_PRE      = 3'b000,
      ITD_PH_ASSERT   = 3'b001,
      ITD_PH_CHK1     = 3'b010,
      ITD_PH_DEASSERT = 3'b011,
      ITD_PH_CHK0     = 3'b100
   } itd_phase_t;

   typedef enum logic [1:0] {
      ITD_ST_IDLE   = 2'b00,
      ITD_ST_SETTLE = 2'b01,
      ITD_ST_CHECK  = 2'b10
   } itd_state_t;

   typedef struct packed {
      itd_state_t       state;
      logic [CNT_W-1:0] cnt;
      itd_if_t          typ;
      itd_phase_t       phase;
      logic             slave;
      logic [NWIRE-1:0] drive;
      logic [NWIRE-1:0] pins;
      logic [NWIRE-1:0] observed;
      logic             link_ok;
      logic             done;
      logic             pass;
      logic             busy;
      logic [31:0]      aff_low;
      logic [31:0]      aff_high;
   } itd_regs_t;

   localparam itd_regs_t ITD_REGS_RESET = '{
      state:    ITD_ST_IDLE,
      cnt:      3'h0,
      typ:      ITD_IF_TRACE,
      phase:    ITD_PH_PRE,
      slave:    1'b0,
      drive:    8'h00,
      pins:     8'h00,
      observed: 8'h00,
      link_ok:  1'b0,
      done:     1'b0,
      pass:     1'b0,
      busy:     1'b0,
      aff_low:  AFF_LOW_VALUE,
      aff_high: AFF_HIGH_VALUE
   };

endpackage

// >>> itd_sync.sv
// Purpose: two-stage synchroniser bank for asynchronous pin inputs
// Assumes: reset already synchronised to clk_in
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module itd_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   // data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               meta[i]     <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               meta[i]     <= async_in[i];
               sync_out[i] <= meta[i];
            end
         end
      end
   endgenerate

endmodule

// >>> itd_top.sv
// Purpose: topology detection override, readback and step sequencer
// Assumes: functional values come from logic on clk_in, pins are asynchronous
// Notes:   detection steps are commanded one at a time by debug control logic
//
// Functional notes
// - each chosen output can be forced independently; each chosen input reads back.
// - every interface type has preamble, assert, check, deassert, check steps.
// - bidirectional channel instances take the master role in turn, others slave.
// - master side offers one controllable output, slave side the matching input.
// - enough wires are overridable to push the level through passive components.
// - trace bus valid is overridable since bridges block controls while valid low.
// - one master wire may reach several slaves; several slaves may report it.
// - one slave wire may reach several masters; fan-in is tolerated.
// - enough wires are controllable to steer arbitration toward the tested path.
// - halt acknowledge may be forceable only through the boundary-scan path.
// - without halt control, the processor link uses another controllable wire.
// - two affinity words tell which processor this trace unit belongs to.
// - point line carries one bit; its acknowledge, if present, is controllable.
// - channel slave observes input bit 0 and drives its acknowledge only when asynchronous.
// - trace bus: valid and ready cleared, valid set, checked, ready follows.
// - halt link: master drives 0, 1, 0; slave only checks, no pre or post.
// - point line: line and ack low, line high checked then ack high, reverse.
// - channel: output bit low, ack clear, set and check, ack, then mirror.
`timescale 1ns/1ps
module itd_top
   import itd_pkg::*;
(
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             reset_n_in,
   // functional values from the component core
   input  wire logic [NWIRE-1:0] func_value_in,
   // detection control
   input  wire logic             detect_mode_in,
   input  wire logic [NWIRE-1:0] force_enable_in,
   input  wire logic [NWIRE-1:0] force_value_in,
   // step commands
   input  wire logic             cmd_valid_in,
   input  wire logic [1:0]       cmd_if_in,
   input  wire logic [2:0]       cmd_phase_in,
   input  wire logic             cmd_slave_in,
   // boundary-scan halt control
   input  wire logic             scan_halt_force_in,
   input  wire logic             scan_halt_value_in,
   // channel link configuration pin
   input  wire logic             chan_async_in,
   // wires from the far components
   input  wire logic             trace_valid_in,
   input  wire logic             trace_ready_in,
   input  wire logic             halt_acknowledge_in,
   input  wire logic             alt_link_in,
   input  wire logic             point_line_in,
   input  wire logic             point_line_ack_in,
   input  wire logic             channel_input_line_in,
   input  wire logic             channel_input_ack_line_in,
   // wires to the far components
   output logic                  trace_valid_out,
   output logic                  trace_ready_out,
   output logic                  halt_acknowledge_out,
   output logic                  alt_link_out,
   output logic                  point_line_out,
   output logic                  point_line_ack_out,
   output logic                  channel_output_line_out,
   output logic                  channel_input_ack_line_out,
   // readback and status
   output logic [NWIRE-1:0]      observed_out,
   output logic                  busy_out,
   output logic                  done_out,
   output logic                  pass_out,
   output logic                  link_ok_out,
   output logic [31:0]           device_affinity_low_out,
   output logic [31:0]           device_affinity_high_out
);

   logic             rst_meta;
   logic             rst_n;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync_in;
   logic [NWIRE-1:0] pin_next;
   logic             chan_async;
   logic             scan_force;
   logic             scan_value;
   itd_regs_t        st;
   itd_regs_t        next_st;

   // reset release through two flops, assertion stays asynchronous
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   assign raw_in = {scan_halt_value_in, scan_halt_force_in, chan_async_in,
                    channel_input_ack_line_in, channel_input_line_in,
                    point_line_ack_in, point_line_in, alt_link_in,
                    halt_acknowledge_in, trace_ready_in, trace_valid_in};

   itd_sync #(
      .WIDTH (NSYNC)
   ) u_sync (
      .clk_in   (clk_in),
      .rst_n_in (rst_n),
      .async_in (raw_in),
      .sync_out (sync_in)
   );

   assign chan_async = sync_in[S_CHAN_ASYNC];
   assign scan_force = sync_in[S_SCAN_FORCE];
   assign scan_value = sync_in[S_SCAN_VALUE];

   // master-side wire of each interface type
   function automatic logic [IDX_W-1:0] master_wire(input itd_if_t t);
      logic [IDX_W-1:0] idx;
      idx = IDX_W'(W_TRC_VALID);
      case (t)
         ITD_IF_TRACE: idx = IDX_W'(W_TRC_VALID);
         // no register path to halt acknowledge: fall back to the spare wire
         ITD_IF_HALT:  idx = HALT_MM_FORCE ? IDX_W'(W_HALT_ACK) : IDX_W'(W_ALT_LINK);
         ITD_IF_POINT: idx = IDX_W'(W_POINT);
         ITD_IF_CHAN:  idx = IDX_W'(W_CHAN_OUT);
         default:      idx = IDX_W'(W_TRC_VALID);
      endcase
      return idx;
   endfunction

   // slave-side acknowledge wire and whether it exists
   function automatic logic [IDX_W-1:0] ack_wire(input itd_if_t t);
      logic [IDX_W-1:0] idx;
      idx = IDX_W'(W_TRC_READY);
      case (t)
         ITD_IF_TRACE: idx = IDX_W'(W_TRC_READY);
         ITD_IF_POINT: idx = IDX_W'(W_POINT_ACK);
         ITD_IF_CHAN:  idx = IDX_W'(W_CHAN_ACK);
         default:      idx = IDX_W'(W_TRC_READY);
      endcase
      return idx;
   endfunction

   function automatic logic ack_present(input itd_if_t t, input logic async_link);
      logic p;
      p = 1'b0;
      case (t)
         ITD_IF_TRACE: p = 1'b1;
         ITD_IF_HALT:  p = 1'b0;
         ITD_IF_POINT: p = POINT_ACK_PRESENT;
         ITD_IF_CHAN:  p = async_link;
         default:      p = 1'b0;
      endcase
      return p;
   endfunction

   // per-wire source select; scan path owns halt acknowledge when it asks
   genvar i;
   generate
      for (i = 0; i < NWIRE; i++) begin : g_wire
         if (i == W_HALT_ACK) begin : g_halt
            always_comb begin
               if (scan_force) begin
                  pin_next[i] = scan_value;
               end else if (!detect_mode_in) begin
                  pin_next[i] = func_value_in[i];
               end else if (FORCE_ALLOW[i] && force_enable_in[i]) begin
                  pin_next[i] = force_value_in[i];
               end else begin
                  pin_next[i] = st.drive[i];
               end
            end
         end else begin : g_plain
            always_comb begin
               if (!detect_mode_in) begin
                  pin_next[i] = func_value_in[i];
               end else if (FORCE_ALLOW[i] && force_enable_in[i]) begin
                  pin_next[i] = force_value_in[i];
               end else begin
                  pin_next[i] = st.drive[i];
               end
            end
         end
      end
   endgenerate

   // step sequencer
   always_comb begin
      next_st          = st;
      next_st.done     = 1'b0;
      next_st.pins     = pin_next;
      next_st.observed = sync_in[NWIRE-1:0];
      next_st.aff_low  = AFF_LOW_VALUE;
      next_st.aff_high = AFF_HIGH_VALUE;
      case (st.state)
         ITD_ST_IDLE: begin
            // commands while a step runs are ignored, so steps never overlap
            if (cmd_valid_in && detect_mode_in) begin
               next_st.typ   = itd_if_t'(cmd_if_in);
               next_st.phase = itd_phase_t'(cmd_phase_in);
               next_st.slave = cmd_slave_in;
               next_st.cnt   = SETTLE_LOAD;
               next_st.state = ITD_ST_SETTLE;
               if (!cmd_slave_in) begin
                  case (itd_phase_t'(cmd_phase_in))
                     ITD_PH_PRE:      next_st.drive[master_wire(itd_if_t'(cmd_if_in))] = 1'b0;
                     ITD_PH_ASSERT:   next_st.drive[master_wire(itd_if_t'(cmd_if_in))] = 1'b1;
                     ITD_PH_DEASSERT: next_st.drive[master_wire(itd_if_t'(cmd_if_in))] = 1'b0;
                     default:         next_st.drive = st.drive;
                  endcase
               end else if (itd_phase_t'(cmd_phase_in) == ITD_PH_PRE) begin
                  // a new pair starts assumed connected until a check fails
                  next_st.link_ok = 1'b1;
                  if (ack_present(itd_if_t'(cmd_if_in), chan_async)) begin
                     next_st.drive[ack_wire(itd_if_t'(cmd_if_in))] = 1'b0;
                  end
               end
            end
         end
         ITD_ST_SETTLE: begin
            if (st.cnt == 3'h0) begin
               if (st.slave && (st.phase == ITD_PH_CHK1 || st.phase == ITD_PH_CHK0)) begin
                  next_st.state = ITD_ST_CHECK;
               end else begin
                  next_st.state = ITD_ST_IDLE;
                  next_st.done  = 1'b1;
                  next_st.pass  = 1'b1;
               end
            end else begin
               next_st.cnt = st.cnt - 3'h1;
            end
         end
         ITD_ST_CHECK: begin
            next_st.state = ITD_ST_IDLE;
            next_st.done  = 1'b1;
            // several slaves may see one master; each judges only itself
            if (st.observed[master_wire(st.typ)] == (st.phase == ITD_PH_CHK1)) begin
               next_st.pass = 1'b1;
               if (ack_present(st.typ, chan_async)) begin
                  next_st.drive[ack_wire(st.typ)] = (st.phase == ITD_PH_CHK1);
               end
            end else begin
               next_st.pass    = 1'b0;
               next_st.link_ok = 1'b0;
            end
         end
         default: begin
            next_st.state = ITD_ST_IDLE;
         end
      endcase
      next_st.busy = (next_st.state != ITD_ST_IDLE);
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         st <= ITD_REGS_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign trace_valid_out            = st.pins[W_TRC_VALID];
   assign trace_ready_out            = st.pins[W_TRC_READY];
   assign halt_acknowledge_out       = st.pins[W_HALT_ACK];
   assign alt_link_out               = st.pins[W_ALT_LINK];
   assign point_line_out             = st.pins[W_POINT];
   assign point_line_ack_out         = st.pins[W_POINT_ACK];
   assign channel_output_line_out    = st.pins[W_CHAN_OUT];
   assign channel_input_ack_line_out = st.pins[W_CHAN_ACK];
   assign observed_out               = st.observed;
   assign busy_out                   = st.busy;
   assign done_out                   = st.done;
   assign pass_out                   = st.pass;
   assign link_ok_out                = st.link_ok;
   assign device_affinity_low_out    = st.aff_low;
   assign device_affinity_high_out   = st.aff_high;

   // checks
   a_force_bit_zero: assert property (@(posedge clk_in) disable iff (!rst_n)
      (detect_mode_in && force_enable_in[W_TRC_VALID] && !scan_force)
      |=> trace_valid_out == $past(force_value_in[W_TRC_VALID]))
      else $error("forced trace valid not driven");

   a_func_pass: assert property (@(posedge clk_in) disable iff (!rst_n)
      !detect_mode_in |=> point_line_out == $past(func_value_in[W_POINT]))
      else $error("functional point line not passed through");

   a_master_valid: assert property (@(posedge clk_in) disable iff (!rst_n)
      (st.state == ITD_ST_IDLE && cmd_valid_in && detect_mode_in && !cmd_slave_in
       && cmd_if_in == ITD_IF_TRACE && cmd_phase_in == ITD_PH_ASSERT)
      ##1 (detect_mode_in && !force_enable_in[W_TRC_VALID])
      |=> trace_valid_out)
      else $error("trace valid not asserted by master step");

   a_step_done: assert property (@(posedge clk_in) disable iff (!rst_n)
      (st.state == ITD_ST_IDLE && cmd_valid_in && detect_mode_in)
      |-> ##[2:7] done_out)
      else $error("step did not complete in time");

   a_step_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
      st.state == ITD_ST_SETTLE |=> $stable(st.typ) && $stable(st.phase))
      else $error("step changed while settling");

   a_check_fail: assert property (@(posedge clk_in) disable iff (!rst_n)
      (st.state == ITD_ST_CHECK
       && st.observed[master_wire(st.typ)] != (st.phase == ITD_PH_CHK1))
      |=> !link_ok_out && !pass_out && done_out)
      else $error("wrong level did not clear link");

   a_ready_post: assert property (@(posedge clk_in) disable iff (!rst_n)
      (st.state == ITD_ST_CHECK && st.typ == ITD_IF_TRACE && st.phase == ITD_PH_CHK1
       && st.observed[W_TRC_VALID])
      |=> st.drive[W_TRC_READY])
      else $error("ready not raised after valid seen");

   a_chan_sync_ack: assert property (@(posedge clk_in) disable iff (!rst_n)
      (st.state == ITD_ST_CHECK && st.typ == ITD_IF_CHAN && !chan_async)
      |=> st.drive[W_CHAN_ACK] == $past(st.drive[W_CHAN_ACK]))
      else $error("acknowledge driven on synchronous channel");

   a_scan_halt: assert property (@(posedge clk_in) disable iff (!rst_n)
      scan_force |=> halt_acknowledge_out == $past(scan_value))
      else $error("scan halt value not driven");

   a_halt_force_blocked: assert property (@(posedge clk_in) disable iff (!rst_n)
      (!HALT_MM_FORCE && detect_mode_in && force_enable_in[W_HALT_ACK] && !scan_force)
      |=> halt_acknowledge_out == $past(st.drive[W_HALT_ACK]))
      else $error("halt acknowledge forced from register path");

   a_point_ack: assert property (@(posedge clk_in) disable iff (!rst_n)
      (st.state == ITD_ST_CHECK && st.typ == ITD_IF_POINT && POINT_ACK_PRESENT
       && st.observed[W_POINT] == (st.phase == ITD_PH_CHK1))
      |=> st.drive[W_POINT_ACK] == (st.phase == ITD_PH_CHK1))
      else $error("point acknowledge not following check");

   a_chan_async_ack: assert property (@(posedge clk_in) disable iff (!rst_n)
      (st.state == ITD_ST_CHECK && st.typ == ITD_IF_CHAN && chan_async
       && st.observed[W_CHAN_OUT] == (st.phase == ITD_PH_CHK1))
      |=> st.drive[W_CHAN_ACK] == (st.phase == ITD_PH_CHK1))
      else $error("channel acknowledge not following check");

   a_halt_no_post: assert property (@(posedge clk_in) disable iff (!rst_n)
      (st.state == ITD_ST_CHECK && st.typ == ITD_IF_HALT)
      |=> $stable(st.drive))
      else $error("halt link slave drove a wire");

   a_affinity_fixed: assert property (@(posedge clk_in) disable iff (!rst_n)
      device_affinity_low_out == AFF_LOW_VALUE && device_affinity_high_out == AFF_HIGH_VALUE)
      else $error("affinity word changed");

endmodule

// >>> itd_far_model.sv
// Purpose: far-side wires of the matching debug components
// Assumes: each far wire is looped back to the near wire of the same slot
// Notes:   an unconnected wire shows the inverse level, there is no pull
`timescale 1ns/1ps
module itd_far_model
   import itd_pkg::*;
(
   // clock
   input  wire logic             clk_in,
   // link control
   input  wire logic [NWIRE-1:0] connect_in,
   // wires from and to the design
   input  wire logic [NWIRE-1:0] near_wire_in,
   output logic      [NWIRE-1:0] far_wire_out
);
   // one flop stands for the far component's own output register
   always_ff @(posedge clk_in) begin
      far_wire_out <= near_wire_in ^ ~connect_in;
   end
endmodule

// >>> testbench.sv
// Purpose: self-checking bench for topology detection
// Assumes: design wires looped back through the far model
// Notes:   one instance plays master then slave of its own wires
`timescale 1ns/1ps
module testbench
   import itd_pkg::*;
   ;
   logic             clk_in, reset_n_in, detect_mode_in, cmd_valid_in, cmd_slave_in;
   logic             scan_halt_force_in, scan_halt_value_in, chan_async_in;
   logic [NWIRE-1:0] func_value_in, force_enable_in, force_value_in, connect;
   logic [1:0]       cmd_if_in;
   logic [2:0]       cmd_phase_in;
   logic [NWIRE-1:0] observed_out;
   logic             busy_out, done_out, pass_out, link_ok_out;
   logic [31:0]      aff_lo, aff_hi, rng;
   wire  [NWIRE-1:0] outs, far_wire;
   int               n_fail = 0;
   int               total_checks = 0;
   int               cycles = 0;
   int               mw[4] = '{W_TRC_VALID, W_ALT_LINK, W_POINT, W_CHAN_OUT};
   int               aw[4] = '{W_TRC_READY, -1, W_POINT_ACK, W_CHAN_ACK};

   itd_top i_itd_top (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .func_value_in(func_value_in), .detect_mode_in(detect_mode_in),
      .force_enable_in(force_enable_in), .force_value_in(force_value_in),
      .cmd_valid_in(cmd_valid_in), .cmd_if_in(cmd_if_in), .cmd_phase_in(cmd_phase_in),
      .cmd_slave_in(cmd_slave_in), .scan_halt_force_in(scan_halt_force_in),
      .scan_halt_value_in(scan_halt_value_in), .chan_async_in(chan_async_in),
      .trace_valid_in(far_wire[0]), .trace_ready_in(far_wire[1]),
      .halt_acknowledge_in(far_wire[2]), .alt_link_in(far_wire[3]),
      .point_line_in(far_wire[4]), .point_line_ack_in(far_wire[5]),
      .channel_input_line_in(far_wire[6]), .channel_input_ack_line_in(far_wire[7]),
      .trace_valid_out(outs[0]), .trace_ready_out(outs[1]),
      .halt_acknowledge_out(outs[2]), .alt_link_out(outs[3]),
      .point_line_out(outs[4]), .point_line_ack_out(outs[5]),
      .channel_output_line_out(outs[6]), .channel_input_ack_line_out(outs[7]),
      .observed_out(observed_out), .busy_out(busy_out), .done_out(done_out),
      .pass_out(pass_out), .link_ok_out(link_ok_out),
      .device_affinity_low_out(aff_lo), .device_affinity_high_out(aff_hi));

   itd_far_model i_itd_far_model (.clk_in(clk_in), .connect_in(connect),
      .near_wire_in(outs), .far_wire_out(far_wire));

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // ceiling well above the few hundred cycles the tests need
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 4000) begin
         n_fail++;
         end_of_test();
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic step(input int typ, input int ph, input logic sl);
      int k;
      @(negedge clk_in);
      cmd_valid_in = 1'b1;
      cmd_if_in    = 2'(typ);
      cmd_phase_in = 3'(ph);
      cmd_slave_in = sl;
      @(negedge clk_in);
      cmd_valid_in = 1'b0;
      check(busy_out, 1'b1);
      k = 0;
      while (done_out !== 1'b1 && k < 20) begin
         @(posedge clk_in);
         #1;
         k++;
      end
      check(32'(k < 20), 32'h1);
      check(busy_out, 1'b0);
   endtask

   // ack drive lands with done, the wire follows one edge later
   task automatic ack_chk(input int a, input logic v, input logic on);
      repeat (2) @(posedge clk_in);
      #1;
      if (a >= 0) check(outs[a], v & on);
   endtask

   task automatic seq(input int typ, input logic conn);
      int   m;
      int   a;
      logic on;
      m  = mw[typ];
      a  = aw[typ];
      on = typ == 0 || (typ == 2 && POINT_ACK_PRESENT) || (typ == 3 && chan_async_in);
      connect = conn ? 8'hFF : ~(NWIRE'(1) << m);
      step(typ, ITD_PH_PRE, 1'b0);
      check(outs[m], 1'b0);
      step(typ, ITD_PH_PRE, 1'b1);
      check(link_ok_out, 1'b1);
      ack_chk(a, 1'b0, on);
      step(typ, ITD_PH_ASSERT, 1'b0);
      check(outs[m], 1'b1);
      if (typ == 1) check(outs[W_HALT_ACK], 1'b0);
      step(typ, ITD_PH_CHK1, 1'b1);
      check({pass_out, link_ok_out}, {conn, conn});
      ack_chk(a, conn, on);
      step(typ, ITD_PH_DEASSERT, 1'b0);
      check(outs[m], 1'b0);
      step(typ, ITD_PH_CHK0, 1'b1);
      check(pass_out, conn);
      ack_chk(a, 1'b0, on);
   endtask

   initial begin
      reset_n_in = 1'b0;
      {detect_mode_in, cmd_valid_in, cmd_slave_in} = 3'h0;
      {scan_halt_force_in, scan_halt_value_in} = 2'h0;
      chan_async_in = 1'b1;
      func_value_in = 8'h00;
      force_enable_in = 8'h00;
      force_value_in = 8'h00;
      cmd_if_in = 2'h0;
      cmd_phase_in = 3'h0;
      connect = 8'hFF;
      rng = 32'd61399;
      repeat (2) @(posedge clk_in);
      #1;
      check(outs, 8'h00);
      check(aff_lo, AFF_LOW_VALUE);
      check(aff_hi, AFF_HIGH_VALUE);
      @(negedge clk_in);
      reset_n_in = 1'b1;
      repeat (4) @(negedge clk_in);
      detect_mode_in = 1'b1;
      force_enable_in = 8'hFF;
      for (int i = 0; i < 4; i++) begin
         rng = xs(rng);
         @(negedge clk_in);
         force_value_in = rng[7:0];
         repeat (2) @(posedge clk_in);
         #1;
         check(outs, rng[7:0] & FORCE_ALLOW);
         repeat (5) @(posedge clk_in);
         #1;
         check(observed_out, rng[7:0] & FORCE_ALLOW);
      end
      $display("test force and readback done");
      @(negedge clk_in);
      detect_mode_in = 1'b0;
      for (int i = 0; i < 4; i++) begin
         rng = xs(rng);
         @(negedge clk_in);
         func_value_in = rng[15:8];
         repeat (2) @(posedge clk_in);
         #1;
         check(outs, rng[15:8]);
      end
      @(negedge clk_in);
      func_value_in = 8'h00;
      scan_halt_force_in = 1'b1;
      scan_halt_value_in = 1'b1;
      repeat (5) @(posedge clk_in);
      #1;
      check(outs[W_HALT_ACK], 1'b1);
      @(negedge clk_in);
      scan_halt_value_in = 1'b0;
      repeat (5) @(posedge clk_in);
      #1;
      check(outs[W_HALT_ACK], 1'b0);
      $display("test functional and scan done");
      @(negedge clk_in);
      scan_halt_force_in = 1'b0;
      detect_mode_in = 1'b1;
      force_enable_in = 8'h00;
      for (int t = 0; t < 4; t++) seq(t, 1'b1);
      @(negedge clk_in);
      chan_async_in = 1'b0;
      repeat (3) @(negedge clk_in);
      seq(3, 1'b1);
      $display("test connected sequences done");
      seq(0, 1'b0);
      seq(2, 1'b0);
      $display("test unconnected sequences done");
      end_of_test();
   end
endmodule
